// [verilog/bsdr_pkg.sv]
// Constants, types and encodings for the boundary-scan data registers.
// Assumes a separate TAP state machine supplies decoded state strobes on TCK.
package bsdr_pkg;

    // Instruction register and opcodes
    localparam int BSDR_IR_W = 4;
    localparam logic [3:0] BSDR_OP_EXTEST = 4'h0;
    localparam logic [3:0] BSDR_OP_IDCODE = 4'h1;
    localparam logic [3:0] BSDR_OP_SAMPLE = 4'h2;
    localparam logic [3:0] BSDR_OP_RESET = 4'hc;
    localparam logic [3:0] BSDR_OP_BYPASS = 4'hf;
    localparam logic [3:0] BSDR_IR_CAPTURE = 4'h1;

    // Identification word layout, fixed one in bit 0
    localparam int BSDR_ID_W = 32;
    localparam int BSDR_ID_REV_W = 4;
    localparam int BSDR_ID_PART_W = 16;
    localparam int BSDR_ID_MAKER_W = 11;
    localparam logic BSDR_ID_LSB = 1'b1;

    // Bypass capture value
    localparam logic BSDR_BYPASS_CAPTURE = 1'b0;

    // Cells of one bidirectional pin, shifted in this order
    localparam int BSDR_CELL_DATA = 0;
    localparam int BSDR_CELL_CTRL = 1;
    localparam int BSDR_CELL_PULL = 2;
    localparam int BSDR_CELLS_PER_PIN = 3;
    localparam int BSDR_TWI_CELLS = 2;
    localparam int BSDR_RST_CELLS = 2;

    // Reset time-out per clock configuration
    localparam int BSDR_SYS_PERIOD_NS = 40;
    localparam int BSDR_TOUT_FAST_US = 100;
    localparam int BSDR_TOUT_SLOW_US = 4000;
    localparam int BSDR_TOUT_FAST_CYC = (BSDR_TOUT_FAST_US * 1000) / BSDR_SYS_PERIOD_NS;
    localparam int BSDR_TOUT_SLOW_CYC = (BSDR_TOUT_SLOW_US * 1000) / BSDR_SYS_PERIOD_NS;

    // Synchroniser slots for levels crossing into SYS_CLK
    localparam int BSDR_SYNC_W = 3;
    localparam int BSDR_SY_TEST = 0;
    localparam int BSDR_SY_PIN = 1;
    localparam int BSDR_SY_SLOW = 2;

    // Decoded TAP state strobes, each high for every TCK cycle spent in that state
    typedef struct packed {
        logic logic_reset;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
    } bsdr_tap_t;

    // Core reset sequencer, Gray along hold, wait, run
    typedef enum logic [1:0] {
        BSDR_RST_HOLD = 2'b00,
        BSDR_RST_WAIT = 2'b01,
        BSDR_RST_RUN = 2'b11
    } bsdr_rst_state_t;

endpackage

// [verilog/bsdr_top.sv]
// Boundary-scan data registers, instruction register and pin muxing.
// Assumes an external TAP state machine drives TAP strobes on TCK and
// that the core holds its port registers cleared while in reset.
//
// What this block does
// - Bypass is one stage and holds zero after Capture-DR.
// - ID word is revision, part code and maker code constants.
// - Revision field counts silicon revisions from zero.
// - Opcode 1 selects ID register and is loaded at power-up.
// - Device stays in reset while the reset bit holds one.
// - After a reset bit held past the synchroniser clears, a clock-dependent time-out follows.
// - Reset bit is not latched; reset follows the shifted bit.
// - Instruction register is four bits, sixteen opcodes.
// - All shift registers move least significant bit first.
// - Opcode 0 selects chain and drives latches onto pins.
// - External test: capture pins, shift, update output pins.
// - Opcode 2 captures, shifts, updates latches not on pins.
// - Opcode C selects reset bit, shift only, TAP unaffected.
// - Opcode F selects bypass, capture zero, then shift.
// - No high-impedance opcode; outside EXTEST, reset tri-states all pins.
// - Each pin has pull-up cell plus two-stage pin cell.
// - Scanned pull-up is not-disable, not-direction, port bit.
// - Input data is taken straight from the pin.
// - Each two-wire pin has an extra driver-enable cell.
// - Reset pin has two observe-only cells.
// - Analog scan cells sit at the digital side interface.
// - Scan works with system clock stopped and faster TCK.
`timescale 1ns/1ps
`default_nettype none

module bsdr_top
    import bsdr_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int TWI_PIN_A = 0,
    parameter int TWI_PIN_B = 1,
    // Identity values below are arbitrary
    parameter logic [3:0] ID_REVISION = 4'h0,
    parameter logic [15:0] ID_PART = 16'h1234,
    parameter logic [10:0] ID_MAKER = 11'h055,
    parameter int TOUT_FAST_CYC = BSDR_TOUT_FAST_CYC,
    parameter int TOUT_SLOW_CYC = BSDR_TOUT_SLOW_CYC
)(
    input wire logic SYS_CLK, // System clock
    input wire logic RST_N, // Sync system reset, low
    input wire logic TCK, // Test clock
    input wire bsdr_tap_t TAP, // TAP state strobes
    input wire logic TDI, // Test data in
    output logic TDO, // Test data out
    input wire logic [NUM_PINS-1:0] PORT_OUT, // Core port output bits
    input wire logic [NUM_PINS-1:0] PORT_DIR, // Core direction bits
    input wire logic PULLUP_DISABLE, // Core global pull-up off
    input wire logic [1:0] TWI_EN, // Core two-wire enables
    input wire logic [NUM_PINS-1:0] PIN_IN, // Pad input levels
    output logic [NUM_PINS-1:0] PAD_OUT, // Pad output value
    output logic [NUM_PINS-1:0] PAD_OE_N, // Pad drive, low drives
    output logic [NUM_PINS-1:0] PAD_PULLUP, // Pad pull-up enable
    output logic [1:0] PAD_TWI_EN, // Slew-limited driver on
    input wire logic RESET_PIN_N, // Reset pin level
    input wire logic HV_RESET_DET, // High-voltage reset seen
    input wire logic CLK_CFG_SLOW, // Slow clock configuration
    output logic CORE_RESET_N, // Core reset, low
    output logic [3:0] IR_VALUE // Active instruction
);

    localparam int PIN_CELLS = NUM_PINS * BSDR_CELLS_PER_PIN;
    localparam int TWI_BASE = PIN_CELLS;
    localparam int UPD_W = PIN_CELLS + BSDR_TWI_CELLS;
    localparam int RST_BASE = UPD_W;
    localparam int CHAIN_W = UPD_W + BSDR_RST_CELLS;
    localparam int CNT_W = $clog2(TOUT_SLOW_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_FAST = CNT_W'(TOUT_FAST_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_SLOW = CNT_W'(TOUT_SLOW_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // Instruction register state
    logic [3:0] ir_shift_ff;
    logic [3:0] nxt_ir_shift;
    logic [3:0] ir_ff;
    logic [3:0] nxt_ir;

    // Data register state
    logic bypass_ff;
    logic nxt_bypass;
    logic [BSDR_ID_W-1:0] id_ff;
    logic [BSDR_ID_W-1:0] nxt_id;
    logic rst_bit_ff;
    logic nxt_rst_bit;
    logic [CHAIN_W-1:0] chain_ff;
    logic [CHAIN_W-1:0] nxt_chain;
    logic [UPD_W-1:0] upd_ff;
    logic [UPD_W-1:0] nxt_upd;

    // System-side reset sequencer state
    logic [BSDR_SYNC_W-1:0] sync1_ff;
    logic [BSDR_SYNC_W-1:0] sync2_ff;
    bsdr_rst_state_t rst_state_ff;
    bsdr_rst_state_t nxt_rst_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // Decode and shared terms
    logic sel_chain;
    logic sel_id;
    logic sel_rst;
    logic sel_bypass;
    logic extest_on;
    logic dev_rst_now;
    logic [BSDR_ID_W-1:0] id_word;
    logic [CHAIN_W-1:0] cap_vec;
    logic [NUM_PINS-1:0] sys_pull;
    logic [BSDR_SYNC_W-1:0] sync_src;

    assign id_word = {ID_REVISION, ID_PART, ID_MAKER, BSDR_ID_LSB};

    // Opcode decode
    always_comb
    begin
        sel_chain = 1'b0;
        sel_id = 1'b0;
        sel_rst = 1'b0;
        sel_bypass = 1'b0;
        case (ir_ff)
            BSDR_OP_EXTEST: sel_chain = 1'b1;
            BSDR_OP_SAMPLE: sel_chain = 1'b1;
            BSDR_OP_IDCODE: sel_id = 1'b1;
            BSDR_OP_RESET: sel_rst = 1'b1;
            default: sel_bypass = 1'b1;
        endcase
    end

    assign extest_on = (ir_ff == BSDR_OP_EXTEST);
    assign IR_VALUE = ir_ff;

    // Instruction register next values
    always_comb
    begin
        nxt_ir_shift = ir_shift_ff;
        nxt_ir = ir_ff;
        if (TAP.capture_ir)
        begin
            nxt_ir_shift = BSDR_IR_CAPTURE;
        end
        else if (TAP.shift_ir)
        begin
            nxt_ir_shift = {TDI, ir_shift_ff[3:1]};
        end
        if (TAP.update_ir)
        begin
            nxt_ir = ir_shift_ff;
        end
    end

    // Instruction register, TCK domain only so scan needs no system clock
    // TCK-only scan logic
    always_ff @(posedge TCK)
    begin
        if (TAP.logic_reset)
        begin
            ir_shift_ff <= BSDR_IR_CAPTURE;
            ir_ff <= BSDR_OP_IDCODE;
        end
        else
        begin
            ir_shift_ff <= nxt_ir_shift;
            ir_ff <= nxt_ir;
        end
    end

    // Capture vector for the chain, one slice per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++)
        begin : g_cap
            assign sys_pull[gi] = ~PULLUP_DISABLE & ~PORT_DIR[gi] & PORT_OUT[gi];
            assign cap_vec[gi*BSDR_CELLS_PER_PIN + BSDR_CELL_DATA] = PIN_IN[gi];
            assign cap_vec[gi*BSDR_CELLS_PER_PIN + BSDR_CELL_CTRL] = PORT_DIR[gi];
            assign cap_vec[gi*BSDR_CELLS_PER_PIN + BSDR_CELL_PULL] = sys_pull[gi];
        end
    endgenerate

    assign cap_vec[TWI_BASE] = TWI_EN[0];
    assign cap_vec[TWI_BASE + 1] = TWI_EN[1];
    assign cap_vec[RST_BASE] = RESET_PIN_N;
    assign cap_vec[RST_BASE + 1] = HV_RESET_DET;

    // Data register next values
    always_comb
    begin
        nxt_bypass = bypass_ff;
        nxt_id = id_ff;
        nxt_rst_bit = rst_bit_ff;
        nxt_chain = chain_ff;
        if (TAP.capture_dr)
        begin
            if (sel_bypass)
            begin
                nxt_bypass = BSDR_BYPASS_CAPTURE;
            end
            if (sel_id)
            begin
                nxt_id = id_word;
            end
            if (sel_chain)
            begin
                nxt_chain = cap_vec;
            end
        end
        else if (TAP.shift_dr)
        begin
            if (sel_bypass)
            begin
                nxt_bypass = TDI;
            end
            if (sel_id)
            begin
                nxt_id = {TDI, id_ff[BSDR_ID_W-1:1]};
            end
            if (sel_rst)
            begin
                nxt_rst_bit = TDI;
            end
            if (sel_chain)
            begin
                nxt_chain = {TDI, chain_ff[CHAIN_W-1:1]};
            end
        end
    end

    // Update latches load in both chain opcodes; only EXTEST routes them
    always_comb
    begin
        nxt_upd = upd_ff;
        if (TAP.update_dr && sel_chain)
        begin
            nxt_upd = chain_ff[UPD_W-1:0];
        end
    end

    // Data registers; the reset bit is left alone by its own effect
    always_ff @(posedge TCK)
    begin
        if (TAP.logic_reset)
        begin
            bypass_ff <= BSDR_BYPASS_CAPTURE;
            id_ff <= '0;
            rst_bit_ff <= 1'b0;
            chain_ff <= '0;
            upd_ff <= '0;
        end
        else
        begin
            bypass_ff <= nxt_bypass;
            id_ff <= nxt_id;
            rst_bit_ff <= nxt_rst_bit;
            chain_ff <= nxt_chain;
            upd_ff <= nxt_upd;
        end
    end

    // Serial output mux; the IR scan path wins while it shifts
    always_comb
    begin
        if (TAP.shift_ir)
        begin
            TDO = ir_shift_ff[0];
        end
        else if (sel_chain)
        begin
            TDO = chain_ff[0];
        end
        else if (sel_id)
        begin
            TDO = id_ff[0];
        end
        else if (sel_rst)
        begin
            TDO = rst_bit_ff;
        end
        else
        begin
            TDO = bypass_ff;
        end
    end

    // Immediate reset, combinational so no latch delays it
    // reset bit acts as reset pin
    assign dev_rst_now = rst_bit_ff | ~RESET_PIN_N;

    // Pad muxing; EXTEST owns the pads as soon as it is in the IR
    generate
        for (gi = 0; gi < NUM_PINS; gi++)
        begin : g_pad
            always_comb
            begin
                if (extest_on)
                begin
                    PAD_OUT[gi] = upd_ff[gi*BSDR_CELLS_PER_PIN + BSDR_CELL_DATA];
                    PAD_OE_N[gi] = ~upd_ff[gi*BSDR_CELLS_PER_PIN + BSDR_CELL_CTRL];
                    PAD_PULLUP[gi] = upd_ff[gi*BSDR_CELLS_PER_PIN + BSDR_CELL_PULL];
                end
                else
                begin
                    PAD_OUT[gi] = PORT_OUT[gi];
                    PAD_OE_N[gi] = ~(PORT_DIR[gi] & ~dev_rst_now);
                    PAD_PULLUP[gi] = sys_pull[gi] & ~dev_rst_now;
                end
            end
        end
    endgenerate

    // Two-wire driver enables; contention is left to the controller
    // no interlock with output control
    always_comb
    begin
        if (extest_on)
        begin
            PAD_TWI_EN = upd_ff[TWI_BASE +: BSDR_TWI_CELLS];
        end
        else
        begin
            PAD_TWI_EN = TWI_EN & {2{~dev_rst_now}};
        end
    end

    // Levels into SYS_CLK; analog cells are outside this block
    // digital side only
    assign sync_src[BSDR_SY_TEST] = rst_bit_ff;
    assign sync_src[BSDR_SY_PIN] = ~RESET_PIN_N;
    assign sync_src[BSDR_SY_SLOW] = CLK_CFG_SLOW;

    // Two-flop synchroniser, first stage feeds only the second
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= sync_src;
            sync2_ff <= sync1_ff;
        end
    end

    // Reset sequencer next values
    always_comb
    begin
        nxt_rst_state = rst_state_ff;
        nxt_cnt = cnt_ff;
        case (rst_state_ff)
            BSDR_RST_HOLD:
            begin
                if (!sync2_ff[BSDR_SY_TEST] && !sync2_ff[BSDR_SY_PIN])
                begin
                    nxt_rst_state = BSDR_RST_WAIT;
                    nxt_cnt = sync2_ff[BSDR_SY_SLOW] ? CNT_SLOW : CNT_FAST;
                end
            end
            BSDR_RST_WAIT:
            begin
                if (sync2_ff[BSDR_SY_TEST] || sync2_ff[BSDR_SY_PIN])
                begin
                    nxt_rst_state = BSDR_RST_HOLD;
                end
                else if (cnt_ff == CNT_ZERO)
                begin
                    nxt_rst_state = BSDR_RST_RUN;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            BSDR_RST_RUN:
            begin
                if (sync2_ff[BSDR_SY_TEST] || sync2_ff[BSDR_SY_PIN])
                begin
                    nxt_rst_state = BSDR_RST_HOLD;
                end
            end
            default:
            begin
                nxt_rst_state = BSDR_RST_HOLD;
            end
        endcase
    end

    // Reset sequencer registers
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            rst_state_ff <= BSDR_RST_HOLD;
            cnt_ff <= CNT_ZERO;
        end
        else
        begin
            rst_state_ff <= nxt_rst_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Assert at once, release after the synchronised time-out if the reset outlasted the synchroniser
    // hold core in reset
    assign CORE_RESET_N = (rst_state_ff == BSDR_RST_RUN) & ~dev_rst_now;

endmodule

`default_nettype wire

// [dv/bsdr_top_props.sv]
// Port-level assertions for the boundary-scan data registers.
// Assumes TAP strobes and TDI change just after TCK rises.
`timescale 1ns/1ps
`default_nettype none
module bsdr_top_props
    import bsdr_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int TOUT_FAST_CYC = 4,
    parameter int TOUT_SLOW_CYC = 16
)(
    input wire logic SYS_CLK, // System clock
    input wire logic RST_N, // System reset, low
    input wire logic TCK, // Test clock
    input wire bsdr_tap_t TAP, // State strobes
    input wire logic TDI, // Serial in
    input wire logic TDO, // Serial out
    input wire logic [NUM_PINS-1:0] PORT_OUT, // Core port bits
    input wire logic [NUM_PINS-1:0] PORT_DIR, // Core direction
    input wire logic PULLUP_DISABLE, // Global pull-up off
    input wire logic [1:0] TWI_EN, // Core two-wire enables
    input wire logic [NUM_PINS-1:0] PIN_IN, // Pad levels
    input wire logic [NUM_PINS-1:0] PAD_OUT, // Pad value
    input wire logic [NUM_PINS-1:0] PAD_OE_N, // Pad drive, low
    input wire logic [NUM_PINS-1:0] PAD_PULLUP, // Pad pull-up
    input wire logic [1:0] PAD_TWI_EN, // Slew driver on
    input wire logic RESET_PIN_N, // Reset pin
    input wire logic HV_RESET_DET, // High-voltage reset
    input wire logic CLK_CFG_SLOW, // Long time-out
    input wire logic CORE_RESET_N, // Core reset, low
    input wire logic [3:0] IR_VALUE // Active opcode
);
    logic [31:0] low_cnt_ff;
    logic [31:0] nxt_low_cnt;
    logic byp_sel;
    // Cycles the core has been held in reset since the last release
    always_comb
        nxt_low_cnt = (!RST_N || CORE_RESET_N) ? 32'h0 : low_cnt_ff + 32'h1;
    always_ff @(posedge SYS_CLK)
        low_cnt_ff <= nxt_low_cnt;
    // Anything but the four defined opcodes must fall back to bypass
    assign byp_sel = !(IR_VALUE inside {BSDR_OP_EXTEST, BSDR_OP_IDCODE, BSDR_OP_SAMPLE,
        BSDR_OP_RESET});

    byp_capture_a: assert property (@(posedge TCK) disable iff (TAP.logic_reset)
        byp_sel && TAP.capture_dr |=> !TDO) else $error("bypass did not capture zero");
    byp_shift_a: assert property (@(posedge TCK) disable iff (TAP.logic_reset)
        byp_sel && TAP.shift_dr && !TAP.capture_dr |=> TDO == $past(TDI))
        else $error("bypass is not a single stage");
    id_lsb_a: assert property (@(posedge TCK) disable iff (TAP.logic_reset)
        IR_VALUE == BSDR_OP_IDCODE && TAP.capture_dr |=> TDO == BSDR_ID_LSB)
        else $error("id capture wrong first bit");
    ir_default_a: assert property (@(posedge TCK)
        $fell(TAP.logic_reset) |-> IR_VALUE == BSDR_OP_IDCODE) else $error("default opcode");
    ir_hold_a: assert property (@(posedge TCK) disable iff (TAP.logic_reset)
        !TAP.update_ir |=> $stable(IR_VALUE)) else $error("opcode changed without update");
    reset_bit_a: assert property (@(posedge TCK) disable iff (TAP.logic_reset)
        IR_VALUE == BSDR_OP_RESET && TAP.shift_dr && TDI |=> !CORE_RESET_N)
        else $error("reset bit did not reset core");
    pin_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !RESET_PIN_N |-> !CORE_RESET_N) else $error("reset pin ignored");
    reset_tout_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(CORE_RESET_N) |-> low_cnt_ff >= (CLK_CFG_SLOW ? TOUT_SLOW_CYC : TOUT_FAST_CYC))
        else $error("reset released before time-out");
    pads_core_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IR_VALUE != BSDR_OP_EXTEST && CORE_RESET_N |-> PAD_OUT == PORT_OUT
        && PAD_OE_N == ~PORT_DIR && PAD_TWI_EN == TWI_EN) else $error("pads left core");
    pullup_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IR_VALUE != BSDR_OP_EXTEST && CORE_RESET_N
        |-> PAD_PULLUP == (~PORT_DIR & PORT_OUT & {NUM_PINS{!PULLUP_DISABLE}}))
        else $error("pull-up enable wrong");
    reset_tristate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IR_VALUE != BSDR_OP_EXTEST && !RESET_PIN_N |-> &PAD_OE_N && PAD_PULLUP == '0
        && PAD_TWI_EN == 2'b00) else $error("pads driven in reset");

    cover property (@(posedge TCK) IR_VALUE == BSDR_OP_EXTEST && TAP.update_dr);
    cover property (@(posedge TCK) byp_sel && TAP.shift_dr);
    cover property (@(posedge SYS_CLK) $rose(CORE_RESET_N) && CLK_CFG_SLOW);
endmodule

bind bsdr_top bsdr_top_props #(.NUM_PINS(NUM_PINS), .TOUT_FAST_CYC(TOUT_FAST_CYC),
    .TOUT_SLOW_CYC(TOUT_SLOW_CYC)) u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .TCK(TCK),
    .TAP(TAP), .TDI(TDI), .TDO(TDO), .PORT_OUT(PORT_OUT), .PORT_DIR(PORT_DIR),
    .PULLUP_DISABLE(PULLUP_DISABLE), .TWI_EN(TWI_EN), .PIN_IN(PIN_IN), .PAD_OUT(PAD_OUT),
    .PAD_OE_N(PAD_OE_N), .PAD_PULLUP(PAD_PULLUP), .PAD_TWI_EN(PAD_TWI_EN),
    .RESET_PIN_N(RESET_PIN_N), .HV_RESET_DET(HV_RESET_DET), .CLK_CFG_SLOW(CLK_CFG_SLOW),
    .CORE_RESET_N(CORE_RESET_N), .IR_VALUE(IR_VALUE));
`default_nettype wire

// [dv/bsdr_jtag_ctl.sv]
// Test controller model driving the TAP state strobes and serial data.
// Assumes a free-running test clock; the TAP walk is reduced to strobes.
`timescale 1ns/1ps
`default_nettype none
module bsdr_jtag_ctl
    import bsdr_pkg::*;
(
    input wire logic tck, // Test clock
    output var bsdr_tap_t tap, // State strobes
    output logic tdi, // Serial data to block
    input wire logic tdo // Serial data from block
);
    localparam int LRST = 6;
    localparam int CIR = 5;
    localparam int SIR = 4;
    localparam int UIR = 3;
    localparam int CDR = 2;
    localparam int SDR = 1;
    localparam int UDR = 0;
    // Held in logic reset from time zero so nothing starts undefined
    initial
    begin
        tap = 7'h40;
        tdi = 1'b0;
    end
    // One state per edge; unused data flips so a stale bit never passes
    task automatic step(input int pos, input logic bit_in, input logic use_bit);
        @(posedge tck);
        tap <= (pos < 0) ? 7'h00 : 7'h01 << pos;
        tdi <= use_bit ? bit_in : ~tdi;
    endtask
    task automatic tap_reset();
        step(LRST, 1'b0, 1'b0);
        step(LRST, 1'b0, 1'b0);
        step(-1, 1'b0, 1'b0);
        @(negedge tck);
    endtask
    task automatic scan(input int n, input logic [31:0] din, input logic upd, input logic ir,
        output logic [31:0] dout);
        int k;
        dout = 32'h0;
        step(ir ? CIR : CDR, 1'b0, 1'b0);
        for (k = 0; k < n; k++)
        begin
            step(ir ? SIR : SDR, din[k], 1'b1);
            @(negedge tck);
            dout[k] = tdo;
        end
        if (upd)
            step(ir ? UIR : UDR, 1'b0, 1'b0);
        step(-1, 1'b0, 1'b0);
        @(negedge tck);
    endtask
endmodule
`default_nettype wire

// [dv/boundary_scan_data_regs_tb_top.sv]
// Self-checking bench for the boundary-scan data registers.
// Assumes the controller model and checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_data_regs_tb_top;
    import bsdr_pkg::*;
    localparam int NP = 8;
    localparam int TF = 4;
    localparam int TS = 16;
    // Identity values are arbitrary
    localparam logic [3:0] REV = 4'h0;
    localparam logic [15:0] PART = 16'h1234;
    localparam logic [10:0] MAKER = 11'h055;
    logic sys_clk = 1'b0;
    logic sys_run = 1'b1;
    logic tck = 1'b0;
    logic rst_n = 1'b0;
    logic global_pullup_disable = 1'b0, rpin_n = 1'b1, hv = 1'b0, slow = 1'b0;
    logic tdi, tdo, core_n;
    bsdr_tap_t tap;
    logic [NP-1:0] port_out = 8'h00, port_dir = 8'h00, pin_in = 8'h00;
    logic [NP-1:0] pad_out, pad_oe_n, pad_pu;
    logic [1:0] twi = 2'b00, pad_twi;
    logic [3:0] ir;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Gated so the scan can also be tried with the system clock stopped
    always #20 sys_clk = sys_run ? ~sys_clk : sys_clk;
    // Offset so test clock edges never meet system clock edges
    initial
    begin
        #1.3;
        forever #3 tck = ~tck;
    end
    bsdr_top #(.TOUT_FAST_CYC(TF), .TOUT_SLOW_CYC(TS)) dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .TCK(tck), .TAP(tap), .TDI(tdi), .TDO(tdo),
        .PORT_OUT(port_out), .PORT_DIR(port_dir), .PULLUP_DISABLE(global_pullup_disable), .TWI_EN(twi),
        .PIN_IN(pin_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n), .PAD_PULLUP(pad_pu),
        .PAD_TWI_EN(pad_twi), .RESET_PIN_N(rpin_n), .HV_RESET_DET(hv),
        .CLK_CFG_SLOW(slow), .CORE_RESET_N(core_n), .IR_VALUE(ir));
    bsdr_jtag_ctl ctl (.tck(tck), .tap(tap), .tdi(tdi), .tdo(tdo));
    // Ceiling far above the several hundred test clocks the tests need
    always @(posedge tck)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors++;
            $display("unexpected at %0t: run too long", $time);
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Chain image: pin i at 3i..3i+2, two-wire enables at 24 and 25
    function automatic logic [31:0] chain(input logic [7:0] o, input logic [7:0] c,
        input logic [7:0] p, input logic [1:0] t);
        logic [31:0] v;
        v = {6'h00, t, 24'h0};
        for (int i = 0; i < NP; i++)
            {v[3*i+2], v[3*i+1], v[3*i]} = {p[i], c[i], o[i]};
        return v;
    endfunction
    task automatic load_ir(input logic [3:0] op);
        logic [31:0] d;
        ctl.scan(4, 32'(op), 1'b1, 1'b1, d);
        check(d, 32'(BSDR_IR_CAPTURE), "ir capture");
        check(32'(ir), 32'(op), "ir value");
    endtask
    task automatic pads(input logic [7:0] o, input logic [7:0] c, input logic [7:0] p,
        input logic [1:0] t);
        check({6'h0, pad_twi, pad_pu, pad_oe_n, pad_out}, {6'h0, t, p, ~c, o}, "pads");
    endtask
    task automatic wait_release(input int tout);
        int n;
        n = 0;
        while (core_n !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        check(32'(n >= tout && n <= tout + 6), 32'h1, "time-out length");
    endtask
    task automatic t_idcode();
        logic [31:0] d;
        ctl.tap_reset();
        check(32'(ir), 32'(BSDR_OP_IDCODE), "default opcode");
        ctl.scan(32, 32'h0, 1'b0, 1'b0, d);
        check(d, {REV, PART, MAKER, BSDR_ID_LSB}, "id word");
        $display("test idcode done");
    endtask
    task automatic t_bypass();
        logic [31:0] d;
        for (int op = 3; op < 16; op++)
        begin
            if (op == 12)
                continue;
            load_ir(4'(op));
            ctl.scan(8, 32'ha5, 1'b0, 1'b0, d);
            check(d, 32'h4a, "bypass stream");
        end
        $display("test bypass done");
    endtask
    task automatic t_sample();
        logic [31:0] d;
        @(posedge sys_clk);
        port_out <= 8'h3c;
        port_dir <= 8'h0f;
        pin_in <= 8'h96;
        twi <= 2'b10;
        hv <= 1'b1;
        load_ir(BSDR_OP_SAMPLE);
        ctl.scan(28, chain(8'h5a, 8'hf0, 8'h0c, 2'b11), 1'b1, 1'b0, d);
        check(d, chain(8'h96, 8'h0f, 8'h30, 2'b10) | 32'h0c000000, "snapshot");
        pads(8'h3c, 8'h0f, 8'h30, 2'b10);
        $display("test sample done");
    endtask
    task automatic t_extest();
        logic [31:0] d;
        load_ir(BSDR_OP_EXTEST);
        pads(8'h5a, 8'hf0, 8'h0c, 2'b11);
        @(posedge tck);
        pin_in <= 8'h69;
        ctl.scan(28, chain(8'ha5, 8'h3c, 8'h40, 2'b00), 1'b1, 1'b0, d);
        check(d, chain(8'h69, 8'h0f, 8'h30, 2'b10) | 32'h0c000000, "capture");
        pads(8'ha5, 8'h3c, 8'h40, 2'b00);
        $display("test extest done");
    endtask
    task automatic t_reset_bit();
        logic [31:0] d;
        load_ir(BSDR_OP_RESET);
        ctl.scan(1, 32'h1, 1'b0, 1'b0, d);
        check(32'(core_n), 32'h0, "core reset");
        pads(8'h3c, 8'h00, 8'h00, 2'b00);
        // Hold the bit past the synchroniser, else no time-out follows
        repeat (3) @(posedge sys_clk);
        ctl.scan(1, 32'h0, 1'b0, 1'b0, d);
        check(d, 32'h1, "capture keeps bit");
        check(32'(ir), 32'(BSDR_OP_RESET), "opcode kept");
        wait_release(TF);
        $display("test reset bit done");
    endtask
    task automatic t_reset_pin();
        @(posedge sys_clk);
        slow <= 1'b1;
        rpin_n <= 1'b0;
        @(negedge sys_clk);
        check(32'(core_n), 32'h0, "pin reset");
        // Pulse outlasts the synchroniser, else no time-out follows
        repeat (3) @(posedge sys_clk);
        rpin_n <= 1'b1;
        wait_release(TS);
        $display("test reset pin done");
    endtask
    task automatic t_clock_stop();
        logic [31:0] d;
        sys_run = 1'b0;
        load_ir(BSDR_OP_BYPASS);
        ctl.scan(8, 32'h3c, 1'b0, 1'b0, d);
        check(d, 32'h78, "bypass, clock stopped");
        sys_run = 1'b1;
        $display("test clock stop done");
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_reset_bit();
        t_reset_pin();
        t_clock_stop();
        end_of_test();
    end
endmodule
`default_nettype wire
